// ---- src/sfr_pkg.sv ----
// Shared constants and types for the signature-release link.
// Assumes a 20 MHz system clock; link clock and timing are set below.
package sfr_pkg;
    localparam logic [7:0] CMD_RELEASE = 8'hAB;
    localparam logic [7:0] CMD_PROTECT = 8'hB9;
    // Identification value is arbitrary
    localparam logic [7:0] SIGNATURE = 8'h5A;
    localparam int OP_BITS = 8;
    localparam int DUMMY_BYTES = 3;
    localparam int FRAME_HDR_BITS = OP_BITS * (1 + DUMMY_BYTES);
    localparam int BITCNT_W = 6;
    localparam int SIG_IDX_W = 3;
    localparam int CLK_PERIOD_NS = 50;
    localparam int PU_TIME_MS = 2;
    localparam int PU_TIME_NS = PU_TIME_MS * 1000 * 1000;
    localparam int RES_TIME_NS = 3000;
    localparam int DP_TIME_NS = 3000;
    localparam int PU_CYCLES = (PU_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RES_CYCLES = (RES_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DP_CYCLES = (DP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HALF_SCK_CYCLES = 4;

    typedef enum logic [2:0] {
        M_POWERUP = 3'h0,
        M_STANDBY = 3'h1,
        M_ENTERING = 3'h3,
        M_PROTECTED = 3'h2,
        M_RELEASING = 3'h6
    } sfr_mode_t;

    typedef enum logic [1:0] {
        PH_CMD = 2'h0,
        PH_DUMMY = 2'h1,
        PH_SIG = 2'h3,
        PH_IGNORE = 2'h2
    } sfr_phase_t;

    typedef enum logic [2:0] {
        H_PWRUP = 3'h0,
        H_IDLE = 3'h1,
        H_SHIFT = 3'h3,
        H_TAIL = 3'h2,
        H_GAP = 3'h6
    } sfr_hphase_t;

    typedef enum logic [1:0] {
        OP_PROTECT = 2'h0,
        OP_RELEASE = 2'h1,
        OP_READSIG = 2'h2
    } sfr_op_t;
endpackage

// ---- src/sfr_link_if.sv ----
// Serial link between host controller and flash command logic.
// Serial output idles high while the device does not drive it.
`timescale 1ns/1ps
interface sfr_link_if;
    logic chip_select_n;
    logic sck;
    logic si;
    logic so;
    logic soOe;
    logic soLine;

    assign soLine = soOe ? so : 1'h1;

    modport host (output chip_select_n, output sck, output si, input soLine);
    modport device (input chip_select_n, input sck, input si, output so, output soOe);
endinterface

// ---- src/sfr_sig_shifter.sv ----
// Falling-edge output stage that drives one bit of a word.
// Assumes idx is stable around the falling edge of sck.
`timescale 1ns/1ps
module sfr_sig_shifter #(
    parameter int W = 8,
    parameter int IW = 3
) (
    input wire logic sck,
    input wire logic rst,
    input wire logic active,
    input wire logic [IW-1:0] idx,
    input wire logic [W-1:0] word,
    output logic dout,
    output logic doe
);
    typedef struct packed {
        logic dout;
        logic doe;
    } sfr_shift_t;

    sfr_shift_t sQ;
    sfr_shift_t sD;
    logic [IW-1:0] top;

    always_comb begin
        sD = sQ;
        top = IW'(W - 1) - idx;
        sD.doe = active;
        sD.dout = active ? word[top] : 1'h0;
    end

    always_ff @(negedge sck or posedge rst) begin
        if (rst) begin
            sQ <= '0;
        end else begin
            sQ <= sD;
        end
    end

    assign dout = sQ.dout;
    assign doe = sQ.doe;
endmodule

// ---- src/sfr_device.sv ----
// Flash command logic for protect, release and signature read.
// Assumes the host keeps sck low while chip select changes.
`timescale 1ns/1ps
// What this design does
// R01: In protect mode only release is decoded
// R02: Release ignored while a write cycle runs
// R03: Select low, 8-bit opcode sampled rising
// R04: Early deselect after opcode still releases
// R05: Release delay before standby accepts commands
// R06: Host waits maximum release delay after release
// R07: Release works also outside protect mode
// R08: Fixed 8-bit signature, readable by release only
// R09: Three dummy bytes sampled and ignored
// R10: Signature shifted out on falling edges
// R11: Signature repeats while clocks continue
// R12: Deselect after signature ends in standby
// R13: Power-on reset holds logic, ignores commands
// R14: Ignore commands until power-up delay elapses
// R15: Start in standby, write enable cleared
// R16: Host stays deselected through power-up delay
// R17: Host delays writes until power-up ends
// R18: Below threshold all operations stop
// R19: Protect only if deselect after bit eight
// R20: Delays are parameterised reference clock counts
module sfr_device #(
    parameter int PowerupCycles = sfr_pkg::PU_CYCLES,
    parameter int ReleaseCycles = sfr_pkg::RES_CYCLES,
    parameter int ProtectCycles = sfr_pkg::DP_CYCLES,
    parameter logic [7:0] Signature = sfr_pkg::SIGNATURE
) (
    input wire logic clk_sys,
    input wire logic rst,
    sfr_link_if.device link,
    input wire logic writeBusy,
    input wire logic setWriteEnable,
    input wire logic clearWriteEnable,
    output logic softwareProtectMode,
    output logic powerupDone,
    output logic commandsAllowed,
    output logic writeEnableLatch
);
    import sfr_pkg::*;

    localparam int TW = $clog2(PowerupCycles + ReleaseCycles + ProtectCycles + 1);

    typedef struct packed {
        logic [BITCNT_W-1:0] bitCnt;
        logic [OP_BITS-1:0] opcode;
        sfr_phase_t phase;
        logic [SIG_IDX_W-1:0] sigIdx;
    } sfr_frame_t;

    typedef struct packed {
        logic resTgl;
        logic protTgl;
        logic overTgl;
        logic allowS1;
        logic allowS2;
        logic protS1;
        logic protS2;
    } sfr_event_t;

    typedef struct packed {
        logic csS1;
        logic csS2;
        logic csS3;
        logic csStable;
        logic [2:0] resS;
        logic [2:0] protS;
        logic [2:0] overS;
        sfr_mode_t mode;
        logic [TW-1:0] timer;
        logic resPend;
        logic protArm;
        logic allow;
        logic protMode;
        logic puDone;
        logic wel;
    } sfr_sys_t;

    sfr_frame_t fQ;
    sfr_frame_t fD;
    sfr_event_t eQ;
    sfr_event_t eD;
    sfr_sys_t sQ;
    sfr_sys_t sD;
    logic [OP_BITS-1:0] sh;
    logic frameRst;

    assign frameRst = rst || link.chip_select_n;

    // Link side, clocked by the serial clock
    always_comb begin
        fD = fQ;
        eD = eQ;
        sh = {fQ.opcode[OP_BITS-2:0], link.si}; // R03
        eD.allowS1 = sQ.allow;
        eD.allowS2 = eQ.allowS1;
        eD.protS1 = sQ.protMode;
        eD.protS2 = eQ.protS1;
        if (fQ.bitCnt != BITCNT_W'(FRAME_HDR_BITS)) begin
            fD.bitCnt = fQ.bitCnt + 1'h1;
        end
        if (fQ.bitCnt == BITCNT_W'(OP_BITS)) begin
            eD.overTgl = ~eQ.overTgl; // R19
        end
        case (fQ.phase)
            PH_CMD: begin
                fD.opcode = sh;
                if (fQ.bitCnt == BITCNT_W'(OP_BITS - 1)) begin
                    fD.phase = PH_IGNORE;
                    if (eQ.allowS2 && sh == CMD_RELEASE) begin // R02 R07 R14
                        fD.phase = PH_DUMMY;
                        eD.resTgl = ~eQ.resTgl;
                    end else if (eQ.allowS2 && !eQ.protS2 && sh == CMD_PROTECT) begin // R01
                        eD.protTgl = ~eQ.protTgl;
                    end
                end
            end
            PH_DUMMY: begin
                if (fQ.bitCnt == BITCNT_W'(FRAME_HDR_BITS - 1)) begin // R09
                    fD.phase = PH_SIG;
                    fD.sigIdx = '0;
                end
            end
            PH_SIG: begin
                fD.sigIdx = fQ.sigIdx + 1'h1; // R11
            end
            default: begin
                fD.phase = PH_IGNORE;
            end
        endcase
    end

    always_ff @(posedge link.sck or posedge frameRst) begin
        if (frameRst) begin
            fQ <= '0;
        end else begin
            fQ <= fD;
        end
    end

    always_ff @(posedge link.sck or posedge rst) begin
        if (rst) begin
            eQ <= '0;
        end else begin
            eQ <= eD;
        end
    end

    // Signature output on falling edges
    sfr_sig_shifter #(
        .W(OP_BITS),
        .IW(SIG_IDX_W)
    ) u_shift (
        .sck(link.sck),
        .rst(frameRst),
        .active(fQ.phase == PH_SIG), // R08 R10
        .idx(fQ.sigIdx),
        .word(Signature),
        .dout(link.so),
        .doe(link.soOe)
    );

    // System side: mode, delays and gating
    always_comb begin
        logic csRise;
        logic csFall;
        logic resEv;
        logic protEv;
        logic overEv;
        csRise = 1'h0;
        csFall = 1'h0;
        resEv = 1'h0;
        protEv = 1'h0;
        overEv = 1'h0;
        sD = sQ;
        sD.csS1 = link.chip_select_n;
        sD.csS2 = sQ.csS1;
        sD.csS3 = sQ.csS2;
        if (sQ.csS2 == sQ.csS3 && sQ.csS3 != sQ.csStable) begin
            sD.csStable = sQ.csS3;
            csRise = sQ.csS3;
            csFall = !sQ.csS3;
        end
        sD.resS = {sQ.resS[1:0], eQ.resTgl};
        sD.protS = {sQ.protS[1:0], eQ.protTgl};
        sD.overS = {sQ.overS[1:0], eQ.overTgl};
        resEv = sQ.resS[1] ^ sQ.resS[2];
        protEv = sQ.protS[1] ^ sQ.protS[2];
        overEv = sQ.overS[1] ^ sQ.overS[2];
        if (csFall) begin
            sD.resPend = 1'h0;
            sD.protArm = 1'h0;
        end
        if (resEv) begin
            sD.resPend = 1'h1;
        end
        if (protEv) begin
            sD.protArm = 1'h1;
        end
        if (overEv) begin
            sD.protArm = 1'h0; // R19
        end
        sD.timer = sQ.timer + 1'h1;
        case (sQ.mode)
            M_POWERUP: begin
                if (sQ.timer == TW'(PowerupCycles - 1)) begin // R14 R20
                    sD.mode = M_STANDBY; // R15
                end
            end
            M_STANDBY, M_PROTECTED: begin
                sD.timer = '0;
                if (csRise && sQ.resPend) begin // R04 R12
                    sD.mode = M_RELEASING;
                    sD.resPend = 1'h0;
                end else if (csRise && sQ.protArm && sQ.mode == M_STANDBY) begin // R19
                    sD.mode = M_ENTERING;
                    sD.protArm = 1'h0;
                end
            end
            M_ENTERING: begin
                if (sQ.timer == TW'(ProtectCycles - 1)) begin // R20
                    sD.mode = M_PROTECTED;
                end
            end
            M_RELEASING: begin
                if (sQ.timer == TW'(ReleaseCycles - 1)) begin // R05 R20
                    sD.mode = M_STANDBY;
                end
            end
            default: begin
                sD.mode = M_POWERUP;
            end
        endcase
        sD.allow = (sD.mode == M_STANDBY || sD.mode == M_PROTECTED) && !writeBusy; // R02 R05 R14
        sD.protMode = sD.mode == M_PROTECTED;
        sD.puDone = sD.mode != M_POWERUP;
        if (clearWriteEnable) begin
            sD.wel = 1'h0;
        end
        if (setWriteEnable && sQ.puDone) begin
            sD.wel = 1'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sQ <= '0; // R13 R15 R18
            sQ.csS1 <= 1'h1;
            sQ.csS2 <= 1'h1;
            sQ.csS3 <= 1'h1;
            sQ.csStable <= 1'h1;
        end else begin
            sQ <= sD;
        end
    end

    assign softwareProtectMode = sQ.protMode;
    assign powerupDone = sQ.puDone;
    assign commandsAllowed = sQ.allow;
    assign writeEnableLatch = sQ.wel;
endmodule

// ---- src/sfr_host.sv ----
// Host controller that issues protect, release and signature reads.
// Assumes one command at a time; sck is made from clk_sys.
`timescale 1ns/1ps
module sfr_host #(
    parameter int PowerupCycles = sfr_pkg::PU_CYCLES,
    parameter int GapCycles = sfr_pkg::RES_CYCLES,
    parameter int HalfCycles = sfr_pkg::HALF_SCK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    sfr_link_if.host link,
    input wire logic cmdValid,
    input wire sfr_pkg::sfr_op_t cmdOp,
    output logic cmdReady,
    output logic [7:0] sigData,
    output logic sigValid
);
    import sfr_pkg::*;

    localparam int TW = $clog2(PowerupCycles + GapCycles + 1);
    localparam int DW = $clog2(HalfCycles + 1);

    typedef struct packed {
        sfr_hphase_t phase;
        logic csn;
        logic sck;
        logic si;
        logic [2:0] soS;
        logic soStable;
        logic ready;
        logic sigValid;
        logic [OP_BITS-1:0] sigData;
        logic isRead;
        logic [DW-1:0] div;
        logic [BITCNT_W-1:0] bitCnt;
        logic [FRAME_HDR_BITS-1:0] tx;
        logic [OP_BITS-1:0] rx;
        logic [TW-1:0] timer;
    } sfr_host_t;

    sfr_host_t hQ;
    sfr_host_t hD;

    always_comb begin
        logic divEnd;
        logic [OP_BITS-1:0] opc;
        logic [BITCNT_W-1:0] total;
        divEnd = 1'h0;
        opc = '0;
        total = '0;
        hD = hQ;
        hD.sigValid = 1'h0;
        hD.soS = {hQ.soS[1:0], link.soLine};
        if (hQ.soS[1] == hQ.soS[2]) begin
            hD.soStable = hQ.soS[2];
        end
        divEnd = hQ.div == DW'(HalfCycles - 1);
        hD.div = divEnd ? '0 : hQ.div + 1'h1;
        hD.timer = hQ.timer + 1'h1;
        opc = (cmdOp == OP_PROTECT) ? CMD_PROTECT : CMD_RELEASE;
        total = hQ.isRead ? BITCNT_W'(FRAME_HDR_BITS + OP_BITS) : BITCNT_W'(OP_BITS);
        case (hQ.phase)
            H_PWRUP: begin
                if (hQ.timer == TW'(PowerupCycles - 1)) begin // R16 R17
                    hD.phase = H_IDLE;
                    hD.ready = 1'h1;
                end
            end
            H_IDLE: begin
                hD.div = '0;
                if (cmdValid) begin
                    hD.ready = 1'h0;
                    hD.csn = 1'h0; // R03
                    hD.tx = {opc, (FRAME_HDR_BITS - OP_BITS)'(0)}; // R09
                    hD.si = opc[OP_BITS-1];
                    hD.isRead = cmdOp == OP_READSIG;
                    hD.bitCnt = '0;
                    hD.phase = H_SHIFT;
                end
            end
            H_SHIFT: begin
                if (divEnd) begin
                    if (!hQ.sck) begin
                        hD.sck = 1'h1;
                        hD.bitCnt = hQ.bitCnt + 1'h1;
                    end else begin
                        hD.sck = 1'h0;
                        if (hQ.bitCnt > BITCNT_W'(FRAME_HDR_BITS)) begin // R10
                            hD.rx = {hQ.rx[OP_BITS-2:0], hQ.soStable};
                        end
                        if (hQ.bitCnt == total) begin // R19
                            hD.phase = H_TAIL;
                        end else begin
                            hD.tx = {hQ.tx[FRAME_HDR_BITS-2:0], 1'h0};
                            hD.si = hQ.tx[FRAME_HDR_BITS-2];
                        end
                    end
                end
            end
            H_TAIL: begin
                if (divEnd) begin
                    hD.csn = 1'h1;
                    hD.si = 1'h0;
                    hD.sigValid = hQ.isRead;
                    hD.sigData = hQ.isRead ? hQ.rx : hQ.sigData;
                    hD.phase = H_GAP;
                    hD.timer = '0;
                end
            end
            H_GAP: begin
                if (hQ.timer == TW'(GapCycles - 1)) begin // R06
                    hD.phase = H_IDLE;
                    hD.ready = 1'h1;
                end
            end
            default: begin
                hD.phase = H_PWRUP;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hQ <= '0;
            hQ.csn <= 1'h1; // R16
            hQ.soS <= 3'h7;
            hQ.soStable <= 1'h1;
        end else begin
            hQ <= hD;
        end
    end

    assign link.chip_select_n = hQ.csn;
    assign link.sck = hQ.sck;
    assign link.si = hQ.si;
    assign cmdReady = hQ.ready;
    assign sigData = hQ.sigData;
    assign sigValid = hQ.sigValid;
endmodule

// ---- bench/sfr_properties.sv ----
// Timing checks on the host-device link and device status outputs.
// Assumes link signals and device status taken plainly from the top.
`timescale 1ns/1ps
module sfr_properties #(
    parameter int PowerupCycles = 20,
    parameter int ReleaseCycles = 8,
    parameter logic [7:0] Signature = 8'h5A
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic chip_select_n,
    input wire logic sck,
    input wire logic so,
    input wire logic soOe,
    input wire logic soLine,
    input wire logic powerupDone,
    input wire logic commandsAllowed,
    input wire logic softwareProtectMode
);
    logic [5:0] bitCnt_q;
    logic [15:0] cycCnt_q;
    logic [7:0] lowCnt_q;

    // Rising sck edges in the current frame
    always_ff @(posedge sck or posedge chip_select_n) begin
        if (chip_select_n) begin
            bitCnt_q <= 6'h00;
        end else if (bitCnt_q != 6'h3F) begin
            bitCnt_q <= bitCnt_q + 6'h01;
        end
    end

    // Cycles since reset and cycles with commands blocked
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cycCnt_q <= 16'h0000;
            lowCnt_q <= 8'h00;
        end else begin
            if (cycCnt_q != 16'hFFFF) begin
                cycCnt_q <= cycCnt_q + 16'h0001;
            end
            if (commandsAllowed) begin
                lowCnt_q <= 8'h00;
            end else if (lowCnt_q != 8'hFF) begin
                lowCnt_q <= lowCnt_q + 8'h01;
            end
        end
    end

    a_oe_after_header: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(soOe) |-> bitCnt_q == 6'h20) else $error("so driven before header done");
    a_so_falling_only: assert property (@(posedge clk_sys) disable iff (rst)
        soOe && sck && $past(sck) |-> $stable(so)) else $error("so changed while sck high");
    a_sig_msb_first: assert property (@(negedge sck) disable iff (rst)
        soOe && !$past(soOe) |-> so == Signature[7]) else $error("first signature bit wrong");
    a_sig_repeats: assert property (@(negedge sck) disable iff (rst)
        soOe && bitCnt_q > 6'h20 |-> so == Signature[3'h7 - 3'(bitCnt_q - 6'h21)])
        else $error("signature bit out of place");
    a_oe_off_deselect: assert property (@(posedge clk_sys) disable iff (rst)
        chip_select_n |-> !soOe && soLine) else $error("so driven while deselected");
    a_powerup_count: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(powerupDone) |-> cycCnt_q == 16'(PowerupCycles)) else $error("power-up delay wrong");
    a_powerup_gate: assert property (@(posedge clk_sys) disable iff (rst)
        !powerupDone |-> !soOe && !commandsAllowed) else $error("active before power-up");
    a_release_delay: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(commandsAllowed) && $past(powerupDone) |-> lowCnt_q >= 8'(ReleaseCycles))
        else $error("standby before release delay");
    a_release_bounded: assert property (@(posedge clk_sys) disable iff (rst)
        powerupDone && !commandsAllowed |-> lowCnt_q <= 8'(ReleaseCycles + 8)) else $error("release too slow");
    a_protect_deselect: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(softwareProtectMode) |-> chip_select_n && $past(chip_select_n, 4))
        else $error("protect entered while selected");
endmodule

// ---- bench/sfr_tb_top.sv ----
// Bench joining host and device, plus a second device driven directly.
// Assumes the package constants; delays are shortened by parameters.
`timescale 1ns/1ps
module sfr_tb_top;
    import sfr_pkg::*;
    localparam int PuC = 20;
    localparam int RelC = 8;
    localparam int ProC = 8;
    localparam int GapC = 12;
    localparam int HalfC = 4;
    logic clk_sys = 0;
    logic rst = 1;
    logic cmdValid = 0;
    sfr_op_t cmdOp = OP_PROTECT;
    logic cmdReady, sigValid, softwareProtectMode, spmB, welB, powerupDone, commandsAllowed;
    logic [7:0] sigData;
    logic [7:0] rdB;
    logic welA;
    logic writeBusy = 0;
    logic setWe = 0;
    logic clrWe = 0;
    logic spmExp = 0;
    int num_errors = 0;
    int samples_checked = 0;
    int seed = 32'hB4CBC172;
    logic [7:0] expA[$];
    logic [7:0] expB[$];
    event bDone;

    sfr_link_if la();
    sfr_link_if lb();

    initial forever #25 clk_sys = ~clk_sys;

    initial begin
        lb.chip_select_n = 1;
        lb.sck = 0;
        lb.si = 0;
    end

    sfr_host #(.PowerupCycles(PuC), .GapCycles(GapC), .HalfCycles(HalfC)) sfr_host_inst (.clk_sys(clk_sys), .rst(rst),
        .link(la.host), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdReady(cmdReady), .sigData(sigData),
        .sigValid(sigValid));
    sfr_device #(.PowerupCycles(PuC), .ReleaseCycles(RelC), .ProtectCycles(ProC)) sfr_device_inst (.clk_sys(clk_sys),
        .rst(rst), .link(la.device), .writeBusy(1'b0), .setWriteEnable(setWe), .clearWriteEnable(clrWe),
        .softwareProtectMode(softwareProtectMode), .powerupDone(powerupDone), .commandsAllowed(commandsAllowed),
        .writeEnableLatch(welA));
    sfr_device #(.PowerupCycles(PuC), .ReleaseCycles(RelC), .ProtectCycles(ProC)) sfr_device_inst_b (.clk_sys(clk_sys),
        .rst(rst), .link(lb.device), .writeBusy(writeBusy), .setWriteEnable(setWe), .clearWriteEnable(clrWe),
        .softwareProtectMode(spmB), .powerupDone(), .commandsAllowed(), .writeEnableLatch(welB));
    sfr_properties #(.PowerupCycles(PuC), .ReleaseCycles(RelC), .Signature(SIGNATURE)) sfr_properties_inst (
        .clk_sys(clk_sys), .rst(rst), .chip_select_n(la.chip_select_n), .sck(la.sck), .so(la.so), .soOe(la.soOe),
        .soLine(la.soLine), .powerupDone(powerupDone), .commandsAllowed(commandsAllowed),
        .softwareProtectMode(softwareProtectMode));

    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wrap_up();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Host command, then protect state check after the gap
    task automatic hcmd(sfr_op_t op);
        int n;
        if (op == OP_READSIG) begin
            expA.push_back(SIGNATURE);
        end
        spmExp = (op == OP_PROTECT);
        n = 0;
        while (cmdReady !== 1'b1 && n < 2000) begin
            @(posedge clk_sys);
            n++;
        end
        if (cmdReady !== 1'b1) begin
            num_errors++;
        end
        cmdValid <= 1;
        cmdOp <= op;
        @(posedge clk_sys);
        cmdValid <= 0;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (cmdReady !== 1'b1 && n < 2000);
        if (cmdReady !== 1'b1) begin
            num_errors++;
        end
        repeat (6) @(posedge clk_sys);
        chk("protect mode", 8'(spmExp), 8'(softwareProtectMode));
    endtask

    // Direct frame on the second link, 80 ns sck, last 8 so bits kept
    task automatic bframe(logic [7:0] op, int nbits, logic [7:0] e);
        logic [7:0] rd;
        rd = 8'h00;
        expB.push_back(e);
        lb.chip_select_n = 0;
        #40;
        for (int i = 0; i < nbits; i++) begin
            lb.si = (i < 8) ? op[7 - i] : 1'($random(seed));
            #40 lb.sck = 1;
            #30 if (i >= nbits - 8) rd = {rd[6:0], lb.soLine};
            #10 lb.sck = 0;
        end
        #40 lb.chip_select_n = 1;
        rdB = rd;
        ->bDone;
        #1000;
    endtask

    always @(posedge clk_sys) begin
        if (sigValid === 1'b1) begin
            if (expA.size() == 0) begin
                chk("unexpected signature", 8'h00, 8'hFF);
            end else begin
                chk("host signature", expA.pop_front(), sigData);
            end
        end
    end

    always @(bDone) begin
        chk("link so", expB.pop_front(), rdB);
    end

    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 0;
        bframe(CMD_RELEASE, 40, 8'hFF);
        chk("write latch", 8'h00, 8'(welB));
        chk("write latch a", 8'h00, 8'(welA));
        chk("protect mode b", 8'h00, 8'(spmB));
        @(posedge clk_sys);
        setWe <= 1;
        @(posedge clk_sys);
        setWe <= 0;
        clrWe <= 0;
        repeat (2) @(posedge clk_sys);
        chk("write latch set", 8'h01, 8'(welB));
        chk("write latch set a", 8'h01, 8'(welA));
        clrWe <= 1;
        @(posedge clk_sys);
        clrWe <= 0;
        repeat (2) @(posedge clk_sys);
        chk("write latch clear", 8'h00, 8'(welB));
        chk("write latch clear a", 8'h00, 8'(welA));
        writeBusy <= 1;
        @(posedge clk_sys);
        bframe(CMD_RELEASE, 40, 8'hFF);
        @(posedge clk_sys);
        writeBusy <= 0;
        bframe(CMD_PROTECT, 9, 8'hFF);
        chk("protect ninth bit", 8'h00, 8'(spmB));
        bframe(CMD_PROTECT, 8, 8'hFF);
        chk("protect entry", 8'h01, 8'(spmB));
        bframe(8'h00, 40, 8'hFF);
        chk("protect kept", 8'h01, 8'(spmB));
        bframe(CMD_RELEASE, 12, 8'hFF);
        chk("early release", 8'h00, 8'(spmB));
        bframe(CMD_RELEASE, 48, SIGNATURE);
        hcmd(OP_READSIG);
        hcmd(OP_PROTECT);
        hcmd(OP_READSIG);
        hcmd(OP_PROTECT);
        hcmd(OP_RELEASE);
        for (int k = 0; k < 12; k++) begin
            hcmd(sfr_op_t'(2'($unsigned($random(seed)) % 3)));
        end
        repeat (20) @(posedge clk_sys);
        chk("pending reads", 8'h00, 8'(expA.size()));
        wrap_up();
    end

    initial begin
        #2000000;
        num_errors++;
        wrap_up();
    end
endmodule
